// >>> logic/mard_pkg.sv
package mard_pkg;
	localparam logic [1:0] MARD_SEL_LOW = 2'h0;
	localparam logic [1:0] MARD_SEL_HIGH = 2'h1;
	localparam logic [1:0] MARD_SEL_REMAP = 2'h2;
	localparam logic [31:0] MARD_RESET_VAL = 32'h0;
	localparam logic [1:0] MARD_TYPE_NORMAL = 2'h2;
	localparam logic [3:0] MARD_NIB_ZERO = 4'h0;
	localparam logic [3:0] MARD_NIB_NC = 4'h4;
	localparam logic [1:0] MARD_F_NC = 2'h0;
	localparam logic [1:0] MARD_F_WBWA = 2'h1;
	localparam logic [1:0] MARD_F_WT = 2'h2;
	localparam logic [1:0] MARD_F_WB = 2'h3;

	typedef enum logic [2:0] {
		MARD_MEM_SO = 3'h1,
		MARD_MEM_DEV = 3'h2,
		MARD_MEM_NORMAL = 3'h4
	} mard_mem_t;

	typedef enum logic [1:0] {
		MARD_POL_NC = 2'h0,
		MARD_POL_WT = 2'h1,
		MARD_POL_WB = 2'h2,
		MARD_POL_UNP = 2'h3
	} mard_pol_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] sel;
		logic secure;
		logic pl1;
		logic [31:0] wdata;
	} mard_req_t;

	typedef struct packed {
		mard_mem_t mem;
		logic unpredictable;
		mard_pol_t inner;
		mard_pol_t outer;
		logic inner_ra;
		logic inner_wa;
		logic outer_ra;
		logic outer_wa;
	} mard_attr_t;

	typedef struct packed {
		logic [1:0][31:0] low;
		logic [1:0][31:0] high;
		logic [1:0][31:0] remap;
		logic [31:0] rdata;
		logic ack;
		logic fault;
		logic lock_s1;
		logic lock_s2;
	} mard_state_t;
endpackage

// >>> logic/mard_top.sv
`timescale 1ns/10ps
module mard_top (
	input wire logic clk_in, // core clock
	input wire logic rstn_in, // sync reset, active low
	input wire logic ce_in, // clock enable
	input wire logic secure_config_write_lock_in, // blocks secure copy writes
	input wire logic long_format_in, // long-descriptor format selected
	input wire mard_pkg::mard_req_t req_in, // register move request
	output logic [31:0] rdata_out, // read data
	output logic ack_out, // access completed
	output logic fault_out, // access refused
	input wire logic lookup_secure_in, // lookup uses secure copy
	input wire logic [2:0] descriptor_attribute_index_in, // long-descriptor index
	input wire logic [2:0] type_extension_bits_in, // short-descriptor type extension
	input wire logic c_bit_in, // short-descriptor C bit
	input wire logic b_bit_in, // short-descriptor B bit
	input wire logic [1:0] primary_type_field_in, // type for this index from type map
	output mard_pkg::mard_attr_t attr_out // decoded attributes
);
	mard_pkg::mard_state_t s_q;
	mard_pkg::mard_state_t s_d;

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	logic lock_sync;
	// the lock pin comes from outside the clock domain
	assign lock_sync = s_q.lock_s2;

	// ----------------------------------------
	// register access
	// ----------------------------------------
	logic bank;
	logic sel_low;
	logic sel_high;
	logic sel_remap;
	logic sel_known;
	logic remap_long;
	logic allowed;
	logic any_req;
	logic lock_blk;
	logic rd_ok;
	logic wr_ok;
	logic wr_low;
	logic wr_high;
	logic wr_remap;
	assign bank = req_in.secure;
	assign any_req = req_in.wr || req_in.rd;
	assign sel_low = req_in.sel == mard_pkg::MARD_SEL_LOW;
	assign sel_high = req_in.sel == mard_pkg::MARD_SEL_HIGH;
	assign sel_remap = req_in.sel == mard_pkg::MARD_SEL_REMAP;
	assign sel_known = sel_low || sel_high || sel_remap;
	assign remap_long = sel_remap && long_format_in;
	assign allowed = req_in.pl1 && sel_known && !remap_long;
	assign lock_blk = req_in.secure && lock_sync;
	assign rd_ok = req_in.rd && allowed;
	// locked secure writes are acknowledged but dropped
	assign wr_ok = req_in.wr && allowed && !lock_blk;
	assign wr_low = wr_ok && sel_low;
	assign wr_high = wr_ok && sel_high;
	assign wr_remap = wr_ok && sel_remap;

	// word of the addressed copy
	function automatic logic [31:0] read_word(input mard_pkg::mard_state_t st,
		input logic [1:0] sel, input logic bk);
		logic [31:0] w;
		case (sel)
			mard_pkg::MARD_SEL_LOW: w = st.low[bk];
			mard_pkg::MARD_SEL_HIGH: w = st.high[bk];
			mard_pkg::MARD_SEL_REMAP: w = st.remap[bk];
			default: w = mard_pkg::MARD_RESET_VAL;
		endcase
		return w;
	endfunction

	// every copy and output register back to its reset value
	function automatic mard_pkg::mard_state_t reset_state();
		mard_pkg::mard_state_t r;
		r.low[0] = mard_pkg::MARD_RESET_VAL;
		r.low[1] = mard_pkg::MARD_RESET_VAL;
		r.high[0] = mard_pkg::MARD_RESET_VAL;
		r.high[1] = mard_pkg::MARD_RESET_VAL;
		r.remap[0] = mard_pkg::MARD_RESET_VAL;
		r.remap[1] = mard_pkg::MARD_RESET_VAL;
		r.rdata = mard_pkg::MARD_RESET_VAL;
		r.ack = 1'b0;
		r.fault = 1'b0;
		r.lock_s1 = 1'b0;
		r.lock_s2 = 1'b0;
		return r;
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.lock_s1 = secure_config_write_lock_in;
		s_d.lock_s2 = s_q.lock_s1;
		s_d.ack = 1'b0;
		s_d.fault = 1'b0;
		if (any_req) begin
			s_d.ack = allowed;
			s_d.fault = !allowed;
		end
		if (rd_ok) begin
			s_d.rdata = read_word(s_q, req_in.sel, bank);
		end
		if (wr_low) begin
			s_d.low[bank] = req_in.wdata;
		end
		if (wr_high) begin
			s_d.high[bank] = req_in.wdata;
		end
		if (wr_remap) begin
			s_d.remap[bank] = req_in.wdata;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// clock enable low freezes everything, reset included
	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			if (!rstn_in) begin
				s_q <= reset_state();
			end else begin
				s_q <= s_d;
			end
		end
	end

	assign rdata_out = s_q.rdata;
	assign ack_out = s_q.ack;
	assign fault_out = s_q.fault;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic mard_pkg::mard_attr_t base_attr(input mard_pkg::mard_mem_t mem);
		mard_pkg::mard_attr_t a;
		a.mem = mem;
		a.unpredictable = 1'b0;
		a.inner = mard_pkg::MARD_POL_NC;
		a.outer = mard_pkg::MARD_POL_NC;
		a.inner_ra = 1'b0;
		a.inner_wa = 1'b0;
		a.outer_ra = 1'b0;
		a.outer_wa = 1'b0;
		return a;
	endfunction

	// one nibble of a long-descriptor byte, outer or inner
	function automatic mard_pkg::mard_pol_t nib_pol(input logic [3:0] n);
		mard_pkg::mard_pol_t p;
		case (n)
			4'h0: p = mard_pkg::MARD_POL_UNP;
			4'h1: p = mard_pkg::MARD_POL_WT;
			4'h2: p = mard_pkg::MARD_POL_WT;
			4'h3: p = mard_pkg::MARD_POL_WT;
			4'h4: p = mard_pkg::MARD_POL_NC;
			4'h5: p = mard_pkg::MARD_POL_WB;
			4'h6: p = mard_pkg::MARD_POL_WB;
			4'h7: p = mard_pkg::MARD_POL_WB;
			4'h8: p = mard_pkg::MARD_POL_WT;
			4'h9: p = mard_pkg::MARD_POL_WT;
			4'hA: p = mard_pkg::MARD_POL_WT;
			4'hB: p = mard_pkg::MARD_POL_WT;
			4'hC: p = mard_pkg::MARD_POL_WB;
			4'hD: p = mard_pkg::MARD_POL_WB;
			4'hE: p = mard_pkg::MARD_POL_WB;
			4'hF: p = mard_pkg::MARD_POL_WB;
			default: p = mard_pkg::MARD_POL_UNP;
		endcase
		return p;
	endfunction

	// allocate hints of a nibble; the non-cacheable code carries none
	function automatic logic nib_ra(input logic [3:0] n);
		return (n != mard_pkg::MARD_NIB_NC) && n[1];
	endfunction

	function automatic logic nib_wa(input logic [3:0] n);
		return (n != mard_pkg::MARD_NIB_NC) && n[0];
	endfunction

	function automatic mard_pkg::mard_pol_t fld_pol(input logic [1:0] f);
		mard_pkg::mard_pol_t p;
		case (f)
			mard_pkg::MARD_F_NC: p = mard_pkg::MARD_POL_NC;
			mard_pkg::MARD_F_WBWA: p = mard_pkg::MARD_POL_WB;
			mard_pkg::MARD_F_WT: p = mard_pkg::MARD_POL_WT;
			mard_pkg::MARD_F_WB: p = mard_pkg::MARD_POL_WB;
			default: p = mard_pkg::MARD_POL_NC;
		endcase
		return p;
	endfunction

	// short field hints: read for any cacheable code, write only for 01
	function automatic logic fld_ra(input logic [1:0] f);
		return f != mard_pkg::MARD_F_NC;
	endfunction

	function automatic logic fld_wa(input logic [1:0] f);
		return f == mard_pkg::MARD_F_WBWA;
	endfunction

	// ----------------------------------------
	// per byte long-descriptor decode
	// ----------------------------------------
	logic [31:0] low_sel;
	logic [31:0] high_sel;
	logic [31:0] rmp;
	mard_pkg::mard_attr_t long_attr [8];
	mard_pkg::mard_attr_t short_attr [8];
	assign low_sel = s_q.low[lookup_secure_in];
	assign high_sel = s_q.high[lookup_secure_in];
	assign rmp = s_q.remap[lookup_secure_in];

	// transient encodings decode as plain cacheable policies
	for (genvar m = 0; m < 8; m++) begin : g_byte
		logic [7:0] abyte;
		logic [3:0] up;
		logic [3:0] lo;
		if (m >= 4) begin : g_hi
			assign abyte = high_sel[8 * (m % 4) +: 8];
		end else begin : g_lo
			assign abyte = low_sel[8 * (m % 4) +: 8];
		end
		assign up = abyte[7:4];
		assign lo = abyte[3:0];
		always_comb begin
			long_attr[m] = base_attr(mard_pkg::MARD_MEM_NORMAL);
			if (up == mard_pkg::MARD_NIB_ZERO) begin
				if (lo == mard_pkg::MARD_NIB_ZERO) begin
					long_attr[m].mem = mard_pkg::MARD_MEM_SO;
				end else begin
					long_attr[m].mem = mard_pkg::MARD_MEM_DEV;
					long_attr[m].unpredictable = lo != mard_pkg::MARD_NIB_NC;
				end
			end else begin
				long_attr[m].outer = nib_pol(up);
				long_attr[m].inner = nib_pol(lo);
				long_attr[m].unpredictable = lo == mard_pkg::MARD_NIB_ZERO;
				long_attr[m].outer_ra = nib_ra(up);
				long_attr[m].outer_wa = nib_wa(up);
				long_attr[m].inner_ra = nib_ra(lo);
				long_attr[m].inner_wa = nib_wa(lo);
			end
		end
	end

	// ----------------------------------------
	// per entry short-descriptor decode
	// ----------------------------------------
	for (genvar n = 0; n < 8; n++) begin : g_entry
		logic [1:0] ofld;
		logic [1:0] ifld;
		mard_pkg::mard_pol_t opol;
		mard_pkg::mard_pol_t ipol;
		assign ofld = rmp[2 * n + 16 +: 2];
		assign ifld = rmp[2 * n +: 2];
		assign opol = fld_pol(ofld);
		assign ipol = fld_pol(ifld);
		always_comb begin
			short_attr[n] = base_attr(mard_pkg::MARD_MEM_NORMAL);
			short_attr[n].outer = opol;
			short_attr[n].inner = ipol;
			short_attr[n].outer_ra = fld_ra(ofld);
			short_attr[n].outer_wa = fld_wa(ofld);
			short_attr[n].inner_ra = fld_ra(ifld);
			short_attr[n].inner_wa = fld_wa(ifld);
		end
	end

	// ----------------------------------------
	// lookup output select
	// ----------------------------------------
	logic [2:0] sidx;
	assign sidx = {type_extension_bits_in[0], c_bit_in, b_bit_in};

	always_comb begin
		attr_out = base_attr(mard_pkg::MARD_MEM_SO);
		if (long_format_in) begin
			attr_out = long_attr[descriptor_attribute_index_in];
		end else begin
			case (primary_type_field_in)
				2'h0: begin
					attr_out = base_attr(mard_pkg::MARD_MEM_SO);
				end
				2'h1: begin
					attr_out = base_attr(mard_pkg::MARD_MEM_DEV);
				end
				mard_pkg::MARD_TYPE_NORMAL: begin
					attr_out = short_attr[sidx];
				end
				default: begin
					attr_out = base_attr(mard_pkg::MARD_MEM_SO);
					attr_out.unpredictable = 1'b1;
				end
			endcase
		end
	end
endmodule

// >>> verification/mard_top_assertions.sv
`timescale 1ns/10ps
module mard_top_chk (
	input wire logic clk_in, // core clock
	input wire logic rstn_in, // sync reset
	input wire logic ce_in, // clock enable
	input wire logic long_format_in, // long format
	input wire mard_pkg::mard_req_t req_in, // request
	input wire logic ack_out, // accepted
	input wire logic fault_out, // refused
	input wire logic [1:0] primary_type_field_in, // region type
	input wire mard_pkg::mard_attr_t attr_out // decoded attributes
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence taken;
		ce_in && (req_in.wr || req_in.rd);
	endsequence
	sequence short_normal;
		!long_format_in && primary_type_field_in == mard_pkg::MARD_TYPE_NORMAL;
	endsequence
	chk_one_answer: assert property (taken |=> ack_out != fault_out)
		else $error("no single answer");
	chk_idle_quiet: assert property (ce_in && !req_in.wr && !req_in.rd |=> !ack_out && !fault_out)
		else $error("answer without request");
	chk_priv_fault: assert property (taken and !req_in.pl1 |=> fault_out)
		else $error("low privilege not refused");
	chk_remap_long: assert property (taken and req_in.sel == 2'h2 && long_format_in |=> fault_out)
		else $error("remap access in long format");
	chk_short_normal: assert property (short_normal |-> attr_out.mem == mard_pkg::MARD_MEM_NORMAL)
		else $error("normal type not normal");
	chk_short_other: assert property (!long_format_in && primary_type_field_in != 2'h2 |-> attr_out.mem != mard_pkg::MARD_MEM_NORMAL)
		else $error("non-normal type decoded normal");
	chk_wt_no_wa: assert property (short_normal and attr_out.outer == mard_pkg::MARD_POL_WT |-> !attr_out.outer_wa)
		else $error("write-through with write-allocate");
	chk_nc_no_alloc: assert property (attr_out.outer == mard_pkg::MARD_POL_NC |-> !attr_out.outer_ra && !attr_out.outer_wa)
		else $error("non-cacheable with allocate");
endmodule

bind mard_top mard_top_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
	.long_format_in(long_format_in), .req_in(req_in), .ack_out(ack_out), .fault_out(fault_out),
	.primary_type_field_in(primary_type_field_in), .attr_out(attr_out));

// >>> verification/mard_walker.sv
`timescale 1ns/10ps
module mard_walker (
	input wire logic clk_in, // core clock
	input wire logic [2:0] n_in, // region attribute number
	output logic [2:0] idx_out, // long index
	output logic [2:0] tex_out, // type extension
	output logic c_out, // C bit
	output logic b_out // B bit
);
	// upper extension bits toggle so they must be ignored
	always @(posedge clk_in) begin
		idx_out <= n_in;
		tex_out <= {~n_in[1:0], n_in[2]};
		{c_out, b_out} <= n_in[1:0];
	end
endmodule

// >>> verification/mard_top_tb.sv
`timescale 1ns/10ps
module mard_top_tb;
	localparam logic [31:0] RM = 32'h1BE4E41B;
	logic clk_in = 1'h0;
	logic rstn_in = 1'h0;
	logic lock = 1'h0;
	logic ce = 1'h1;
	logic lng = 1'h1;
	logic sec = 1'h0;
	logic [2:0] wn = 3'h0;
	logic [1:0] tp = 2'h2;
	mard_pkg::mard_req_t req = '0;
	logic [31:0] rdata;
	logic ack, fault, c, b;
	logic [2:0] idx, type_extension_bits;
	mard_pkg::mard_attr_t attr;
	int mismatches = 0;
	int samples_checked = 0;
	logic [11:0] lx [8] = '{12'h200, 12'h400, 12'h8AF, 12'h800, 12'h850, 12'h85A, 12'h88C, 12'h9C0};
	logic [3:0] pe [4] = '{4'h0, 4'hB, 4'h6, 4'hA};
	mard_top uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
		.secure_config_write_lock_in(lock), .long_format_in(lng), .req_in(req),
		.rdata_out(rdata), .ack_out(ack), .fault_out(fault), .lookup_secure_in(sec),
		.descriptor_attribute_index_in(idx), .type_extension_bits_in(type_extension_bits), .c_bit_in(c),
		.b_bit_in(b), .primary_type_field_in(tp), .attr_out(attr));
	mard_walker wlk (.clk_in(clk_in), .n_in(wn), .idx_out(idx), .tex_out(type_extension_bits), .c_out(c),
		.b_out(b));
	initial forever #10 clk_in = ~clk_in;
	initial begin
		#20000;
		mismatches++;
		results();
	end
	task results;
		if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task acc(input logic w, input logic [1:0] s, input logic sc, input logic p,
		input logic [31:0] d, input logic f);
		req <= '{w, !w, s, sc, p, d};
		@(posedge clk_in);
		req <= '0;
		@(negedge clk_in);
		cmp({31'h0, fault}, {31'h0, f});
		cmp({31'h0, ack}, {31'h0, !f});
		@(posedge clk_in);
	endtask
	task look(input logic [2:0] n, input logic [11:0] e, input logic full);
		logic [11:0] m;
		m = full ? 12'hFFF : 12'hE00;
		wn <= n;
		@(posedge clk_in);
		@(negedge clk_in);
		cmp({20'h0, attr & m}, {20'h0, e & m});
		@(posedge clk_in);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [3:0] pi, po;
		repeat (20) @(posedge clk_in);
		rstn_in <= 1'h1;
		@(posedge clk_in);
		acc(1'h0, 2'h0, 1'h0, 1'h1, 32'h0, 1'h0);
		cmp(rdata, 32'h0);
		acc(1'h1, 2'h0, 1'h0, 1'h1, 32'h44FF0400, 1'h0);
		acc(1'h1, 2'h1, 1'h0, 1'h1, 32'h40472288, 1'h0);
		acc(1'h1, 2'h0, 1'h1, 1'h1, 32'h47474747, 1'h0);
		for (int k = 0; k < 8; k++) look(k[2:0], lx[k], k > 1);
		ce <= 1'h0;
		req <= '{1'h1, 1'h0, 2'h0, 1'h0, 1'h1, 32'h12345678};
		@(posedge clk_in);
		req <= '0;
		ce <= 1'h1;
		@(negedge clk_in);
		cmp({31'h0, ack}, 32'h0);
		@(posedge clk_in);
		acc(1'h0, 2'h0, 1'h0, 1'h1, 32'h0, 1'h0);
		cmp(rdata, 32'h44FF0400);
		sec <= 1'h1;
		look(3'h0, 12'h88C, 1'h1);
		lock <= 1'h1;
		repeat (2) @(posedge clk_in);
		acc(1'h1, 2'h0, 1'h1, 1'h1, 32'h0, 1'h0);
		acc(1'h0, 2'h0, 1'h1, 1'h1, 32'h0, 1'h0);
		cmp(rdata, 32'h47474747);
		acc(1'h1, 2'h2, 1'h0, 1'h1, RM, 1'h1);
		acc(1'h0, 2'h0, 1'h0, 1'h0, 32'h0, 1'h1);
		acc(1'h0, 2'h3, 1'h0, 1'h1, 32'h0, 1'h1);
		lng <= 1'h0;
		acc(1'h1, 2'h2, 1'h1, 1'h1, 32'hFFFFFFFF, 1'h0);
		acc(1'h0, 2'h2, 1'h1, 1'h1, 32'h0, 1'h0);
		cmp(rdata, 32'h0);
		sec <= 1'h0;
		acc(1'h1, 2'h2, 1'h0, 1'h1, RM, 1'h0);
		for (int n = 0; n < 8; n++) begin
			pi = pe[RM[2*n +: 2]];
			po = pe[RM[2*n+16 +: 2]];
			look(n[2:0], {4'h8, pi[3:2], po[3:2], pi[1:0], po[1:0]}, 1'h1);
		end
		tp <= 2'h0;
		look(3'h0, 12'h200, 1'h0);
		tp <= 2'h1;
		look(3'h0, 12'h400, 1'h0);
		tp <= 2'h3;
		look(3'h0, 12'h300, 1'h1);
		results();
	end
endmodule
